// ===== rsh_pkg.sv
// Shared constants, codes and helper functions of the reference selector
package rsh_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int DAC_W    = 10;
  localparam int LOCK_W   = 16;
  localparam int MULT_W   = 15;
  localparam int CNTR_W   = 8;
  localparam int SEL_W    = 3;
  localparam int INPUTS   = 3;

  // ---------------------------------------------------------------------
  // Input choices and mode codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] INPUT_ZERO    = 2'h0;
  localparam logic [1:0] INPUT_ONE     = 2'h1;
  localparam logic [1:0] INPUT_TWO     = 2'h2;
  localparam logic [1:0] CHOICE_HOLD   = 2'h3;
  localparam logic       EXIT_BY_LOSS  = 1'h0;

  // ---------------------------------------------------------------------
  // Status pin source codes
  // ---------------------------------------------------------------------
  localparam logic [SEL_W-1:0] STAT_LOW      = 3'h0;
  localparam logic [SEL_W-1:0] STAT_OUTER    = 3'h1;
  localparam logic [SEL_W-1:0] STAT_INNER    = 3'h2;
  localparam logic [SEL_W-1:0] STAT_BOTH     = 3'h3;
  localparam logic [SEL_W-1:0] STAT_HOLDOVER = 3'h4;
  localparam logic [SEL_W-1:0] STAT_DAC_ACQ  = 3'h5;

  // ---------------------------------------------------------------------
  // Reset values and tolerances
  // ---------------------------------------------------------------------
  localparam logic [DAC_W-1:0]  DAC_RESET  = 10'h200;
  localparam logic [DAC_W-1:0]  ACQ_TOL    = 10'h002;
  localparam logic [LOCK_W-1:0] LOCK_ZERO  = 16'h0000;
  localparam logic [LOCK_W-1:0] LOCK_ONE   = 16'h0001;
  localparam logic [LOCK_W-1:0] LOCK_MAX   = 16'hffff;
  localparam logic [MULT_W-1:0] MULT_ZERO  = 15'h0000;
  localparam logic [MULT_W-1:0] MULT_ONE   = 15'h0001;
  localparam logic [CNTR_W-1:0] CNTR_ZERO  = 8'h00;
  localparam logic [CNTR_W-1:0] CNTR_ONE   = 8'h01;
  localparam logic [DAC_W-1:0]  DAC_ONE    = 10'h001;

  // ---------------------------------------------------------------------
  // Holdover states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    HO_RUN  = 2'b01,
    HO_HOLD = 2'b10
  } rsh_hold_type;

  // One-hot view of an input index
  function automatic logic [INPUTS-1:0] rsh_onehot(input logic [1:0] idx);
    rsh_onehot = (idx == INPUT_ZERO) ? 3'h1 :
                 (idx == INPUT_ONE)  ? 3'h2 :
                 (idx == INPUT_TWO)  ? 3'h4 : 3'h0;
  endfunction : rsh_onehot

  // Highest priority eligible input, zero first
  function automatic logic [1:0] rsh_priority(input logic [INPUTS-1:0] ok);
    rsh_priority = ok[0] ? INPUT_ZERO :
                   ok[1] ? INPUT_ONE  : INPUT_TWO;
  endfunction : rsh_priority

  function automatic logic [DAC_W-1:0] rsh_abs_diff(
    input logic [DAC_W-1:0] a,
    input logic [DAC_W-1:0] b);
    rsh_abs_diff = (a > b) ? a - b : b - a;
  endfunction : rsh_abs_diff

endpackage : rsh_pkg

// ===== rsh_lock_if.sv
// Phase comparison and lock flag carrier between selector and detectors
`timescale 1ns/1ps
interface rsh_lock_if;
  logic                       strobe;
  logic                       in_window;
  logic [rsh_pkg::LOCK_W-1:0] target;
  logic                       lock;

  modport ctrl (output strobe, output in_window, output target, input lock);
  modport det  (input strobe, input in_window, input target, output lock);
endinterface : rsh_lock_if

// ===== rsh_lock_detect.sv
// Digital lock detector: counts in-window comparisons, flags lock at a target
`timescale 1ns/1ps
module rsh_lock_detect (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Comparison events and lock flag
  rsh_lock_if.det   cmp
);
  import rsh_pkg::*;

  logic [LOCK_W-1:0] count;
  logic              lock;

  wire [LOCK_W-1:0] inc_count = (count == LOCK_MAX) ? count : count + LOCK_ONE;
  wire [LOCK_W-1:0] next_count =
    !cmp.strobe   ? count :
    cmp.in_window ? inc_count : LOCK_ZERO;
  wire next_lock =
    !cmp.strobe   ? lock :
    cmp.in_window ? (inc_count >= cmp.target) : 1'b0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= LOCK_ZERO;
      lock  <= 1'b0;
    end else begin
      count <= next_count;
      lock  <= next_lock;
    end
  end

  assign cmp.lock = lock;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_miss_clears;
    @(posedge clk_sys) disable iff (!nrst)
      cmp.strobe && !cmp.in_window |=> !lock && count == LOCK_ZERO;
  endproperty
  a_miss_clears: assert property (p_miss_clears)
    else $error("lock not cleared after out-of-window comparison");

  property p_target_locks;
    @(posedge clk_sys) disable iff (!nrst)
      cmp.strobe && cmp.in_window && (inc_count >= cmp.target) |=> lock;
  endproperty
  a_target_locks: assert property (p_target_locks)
    else $error("lock flag missing at target count");

  property p_count_steps;
    @(posedge clk_sys) disable iff (!nrst)
      cmp.strobe && cmp.in_window && count != LOCK_MAX
        |=> count == $past(count) + LOCK_ONE;
  endproperty
  a_count_steps: assert property (p_count_steps)
    else $error("lock count did not step on in-window comparison");

endmodule : rsh_lock_detect

// ===== rsh_ref_select.sv
// Reference selection, lock status and holdover control of a dual loop
`timescale 1ns/1ps
// Summary of operation
// - Manual mode when both select enables clear
// - Choice 0/1/2 picks input zero/one/two
// - Manual mode runs chosen buffer regardless
// - Choice 3 holds; exit relocks chosen input
// - Pin mode picks input from pins
// - Polarity bit inverts select pin sense
// - Pin mode runs chosen buffer regardless
// - Automatic mode: fixed priority zero, one, two
// - Automatic mode needs buffer enable for eligibility
// - In-window comparison increments loop lock count
// - Lock flag asserts at programmed target
// - Status pins show outer, inner or both
// - Holdover only when holdover enable set
// - Fixed mode drives fixed value in holdover
// - Tracked mode drives tracked value in holdover
// - Acquired flag set; selectable on status pins
// - DAC updates every multiplier times counter ticks
// - Holdover: pump off, outer unlock, status set
// - Holdover exits by reprogram or returning input
// - Fixed enable overrides tracked value throughout holdover
module rsh_ref_select
  import rsh_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // Input selection configuration
  input  wire logic                       auto_select_enable,
  input  wire logic                       pin_select_enable,
  input  wire logic [1:0]                 manual_input_choice,
  input  wire logic [rsh_pkg::INPUTS-1:0] input_buffer_enable,
  input  wire logic                       select_pin_polarity,
  input  wire logic                       loss_of_signal_enable,
  input  wire logic                       holdover_exit_choice,
  // Holdover configuration
  input  wire logic                       holdover_enable,
  input  wire logic                       fixed_dac_enable,
  input  wire logic                       dac_tracking_enable,
  input  wire logic [rsh_pkg::DAC_W-1:0]  fixed_dac_value,
  input  wire logic [rsh_pkg::MULT_W-1:0] dac_rate_multiplier,
  input  wire logic [rsh_pkg::CNTR_W-1:0] dac_rate_counter,
  // Lock detect and status configuration
  input  wire logic [rsh_pkg::LOCK_W-1:0] loop1_lock_count_target,
  input  wire logic [rsh_pkg::LOCK_W-1:0] loop2_lock_count_target,
  input  wire logic [rsh_pkg::SEL_W-1:0]  status_pin_one_select,
  input  wire logic [rsh_pkg::SEL_W-1:0]  status_pin_two_select,
  // Select and status pins
  input  wire logic                       select_pin_zero,
  input  wire logic                       select_pin_one,
  input  wire logic                       status_pin_one_in,
  output logic                            status_pin_one_out,
  output logic                            status_pin_one_oe,
  output logic                            status_pin_two,
  // Reference monitors and loop events
  input  wire logic [rsh_pkg::INPUTS-1:0] loss_of_signal,
  input  wire logic                       loop1_pd_tick,
  input  wire logic                       loop1_compare_strobe,
  input  wire logic                       loop1_in_window,
  input  wire logic                       loop2_compare_strobe,
  input  wire logic                       loop2_in_window,
  input  wire logic [rsh_pkg::DAC_W-1:0]  loop1_tune_voltage,
  // Selection and holdover outputs
  output logic [1:0]                      active_input,
  output logic [rsh_pkg::INPUTS-1:0]      buffer_run,
  output logic                            holdover_status,
  output logic                            charge_pump_tristate,
  output logic                            loop1_lock,
  output logic                            loop2_lock,
  output logic [rsh_pkg::DAC_W-1:0]       loop1_tune_output,
  output logic [rsh_pkg::DAC_W-1:0]       dac_value_readback,
  output logic                            dac_acquired_flag
);
  import rsh_pkg::*;

  // ---------------------------------------------------------------------
  // Lock detectors
  // ---------------------------------------------------------------------
  rsh_lock_if outer_cmp ();
  rsh_lock_if inner_cmp ();

  assign outer_cmp.strobe    = loop1_compare_strobe;
  assign outer_cmp.in_window = loop1_in_window;
  assign outer_cmp.target    = loop1_lock_count_target;
  assign inner_cmp.strobe    = loop2_compare_strobe;
  assign inner_cmp.in_window = loop2_in_window;
  assign inner_cmp.target    = loop2_lock_count_target;

  rsh_lock_detect u_outer_lock (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .cmp     (outer_cmp.det)
  );

  rsh_lock_detect u_inner_lock (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .cmp     (inner_cmp.det)
  );

  // ---------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------
  wire manual_mode = !auto_select_enable && !pin_select_enable;
  wire pin_mode    = !auto_select_enable && pin_select_enable;
  // Automatic switching only acts with loss detection and loss-based exit
  wire auto_valid  = auto_select_enable && loss_of_signal_enable &&
                     (holdover_exit_choice == EXIT_BY_LOSS);

  // Pins are sampled as-is; the host has made them inputs
  wire [1:0] pin_code = {select_pin_one, select_pin_zero} ^
                        {2{select_pin_polarity}};
  // Code 3 uses status pin one: high picks input two, low asks holdover
  wire       pin_hold = (pin_code == CHOICE_HOLD) && !status_pin_one_in;
  wire [1:0] pin_pick = (pin_code == CHOICE_HOLD) ? INPUT_TWO : pin_code;

  wire [INPUTS-1:0] eligible     = input_buffer_enable & ~loss_of_signal;
  wire              any_eligible = |eligible;
  wire [1:0]        auto_pick    = rsh_priority(eligible);

  wire manual_hold = manual_mode && (manual_input_choice == CHOICE_HOLD);
  wire auto_hold   = auto_valid && !any_eligible;

  // Dropping the request, by reprogramming or a returning input, exits
  wire want_hold = holdover_enable &&
                   (manual_hold || (pin_mode && pin_hold) ||
                    auto_hold);

  // ---------------------------------------------------------------------
  // Active input
  // ---------------------------------------------------------------------
  // During a hold request the last input is kept; exit takes the new choice, pin pick or auto pick
  wire [1:0] next_active_input =
    manual_mode ? (manual_hold ? active_input
                               : manual_input_choice) :
    pin_mode    ? (pin_hold ? active_input : pin_pick) :
    (auto_valid && any_eligible) ? auto_pick :
    active_input;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_input <= INPUT_ZERO;
    end else begin
      active_input <= next_active_input;
    end
  end

  // Manual and pin modes force the chosen buffer on
  assign buffer_run = input_buffer_enable |
                      ((manual_mode || pin_mode) ?
                       rsh_onehot(active_input) : 3'h0);

  // ---------------------------------------------------------------------
  // Holdover state
  // ---------------------------------------------------------------------
  rsh_hold_type hold_state;
  rsh_hold_type next_hold_state;

  always_comb begin
    next_hold_state = hold_state;
    unique case (hold_state)
      HO_RUN: begin
        if (want_hold) begin
          next_hold_state = HO_HOLD;
        end
      end
      HO_HOLD: begin
        if (!want_hold) begin
          next_hold_state = HO_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_state <= HO_RUN;
    end else begin
      hold_state <= next_hold_state;
    end
  end

  wire in_hold = (hold_state == HO_HOLD);

  assign holdover_status      = in_hold;
  assign charge_pump_tristate = in_hold;
  // Inner loop lock is untouched by holdover
  assign loop1_lock           = outer_cmp.lock && !in_hold;
  assign loop2_lock           = inner_cmp.lock;

  // ---------------------------------------------------------------------
  // Tracking DAC update rate
  // ---------------------------------------------------------------------
  // Zero settings behave as one so the divider never stalls
  logic [MULT_W-1:0] mult_count;
  logic [CNTR_W-1:0] cntr_count;

  wire [MULT_W-1:0] mult_last = (dac_rate_multiplier == MULT_ZERO) ?
                                MULT_ZERO : dac_rate_multiplier - MULT_ONE;
  wire [CNTR_W-1:0] cntr_last = (dac_rate_counter == CNTR_ZERO) ?
                                CNTR_ZERO : dac_rate_counter - CNTR_ONE;
  wire mult_wrap  = loop1_pd_tick && (mult_count >= mult_last);
  wire cntr_wrap  = mult_wrap && (cntr_count >= cntr_last);
  wire dac_update = cntr_wrap && dac_tracking_enable;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mult_count <= MULT_ZERO;
      cntr_count <= CNTR_ZERO;
    end else if (loop1_pd_tick) begin
      mult_count <= mult_wrap ? MULT_ZERO : mult_count + MULT_ONE;
      if (mult_wrap) begin
        cntr_count <= cntr_wrap ? CNTR_ZERO : cntr_count + CNTR_ONE;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Tracking DAC
  // ---------------------------------------------------------------------
  // One LSB per update: a slow rate lets the held value lag the event
  logic [DAC_W-1:0] track_value;

  wire [DAC_W-1:0] next_track_value =
    (!dac_update || in_hold)            ? track_value :
    (track_value < loop1_tune_voltage)  ? track_value + DAC_ONE :
    (track_value > loop1_tune_voltage)  ? track_value - DAC_ONE :
    track_value;

  wire track_close =
    rsh_abs_diff(next_track_value, loop1_tune_voltage) <= ACQ_TOL;
  wire next_acquired = dac_tracking_enable &&
                       (dac_acquired_flag ||
                        (dac_update && !in_hold && track_close));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      track_value       <= DAC_RESET;
      dac_acquired_flag <= 1'b0;
    end else begin
      track_value       <= next_track_value;
      dac_acquired_flag <= next_acquired;
    end
  end

  assign dac_value_readback = track_value;

  // Outside holdover the pin follows the closed loop tuning voltage
  wire [DAC_W-1:0] next_tune_output =
    !in_hold         ? loop1_tune_voltage :
    fixed_dac_enable ? fixed_dac_value :
    track_value;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loop1_tune_output <= DAC_RESET;
    end else begin
      loop1_tune_output <= next_tune_output;
    end
  end

  // ---------------------------------------------------------------------
  // Status pins
  // ---------------------------------------------------------------------
  function automatic logic status_source(input logic [SEL_W-1:0] sel);
    status_source =
      (sel == STAT_OUTER)    ? loop1_lock :
      (sel == STAT_INNER)    ? loop2_lock :
      (sel == STAT_BOTH)     ? (loop1_lock && loop2_lock) :
      (sel == STAT_HOLDOVER) ? in_hold :
      (sel == STAT_DAC_ACQ)  ? dac_acquired_flag : 1'b0;
  endfunction : status_source

  wire next_status_one = status_source(status_pin_one_select);
  wire next_status_two = status_source(status_pin_two_select);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_pin_one_out <= 1'b0;
      status_pin_two     <= 1'b0;
    end else begin
      status_pin_one_out <= next_status_one;
      status_pin_two     <= next_status_two;
    end
  end

  // Pin select mode reads status pin one, so it is released then
  assign status_pin_one_oe = !pin_mode;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_manual_pick;
    @(posedge clk_sys) disable iff (!nrst)
      manual_mode && manual_input_choice != CHOICE_HOLD
        |=> active_input == $past(manual_input_choice);
  endproperty
  a_manual_pick: assert property (p_manual_pick)
    else $error("manual choice not applied");

  property p_manual_hold;
    @(posedge clk_sys) disable iff (!nrst)
      manual_hold && holdover_enable ##1 manual_hold && holdover_enable
        |-> holdover_status && $stable(active_input);
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("manual hold choice did not hold");

  property p_hold_needs_enable;
    @(posedge clk_sys) disable iff (!nrst)
      !holdover_enable |=> !holdover_status;
  endproperty
  a_hold_needs_enable: assert property (p_hold_needs_enable)
    else $error("holdover without enable");

  property p_auto_priority;
    @(posedge clk_sys) disable iff (!nrst)
      auto_valid && eligible[0] |=> active_input == INPUT_ZERO;
  endproperty
  a_auto_priority: assert property (p_auto_priority)
    else $error("highest priority input not chosen");

  property p_auto_eligible;
    @(posedge clk_sys) disable iff (!nrst)
      auto_valid && any_eligible
        |=> (rsh_onehot(active_input) & $past(eligible)) != 3'h0;
  endproperty
  a_auto_eligible: assert property (p_auto_eligible)
    else $error("ineligible input chosen");

  property p_pin_pick;
    @(posedge clk_sys) disable iff (!nrst)
      pin_mode && !pin_hold |=> active_input == $past(pin_pick);
  endproperty
  a_pin_pick: assert property (p_pin_pick)
    else $error("pin selection not applied");

  property p_buffer_forced;
    @(posedge clk_sys) disable iff (!nrst)
      (manual_mode || pin_mode)
        |-> (buffer_run & rsh_onehot(active_input)) != 3'h0;
  endproperty
  a_buffer_forced: assert property (p_buffer_forced)
    else $error("chosen buffer not running");

  property p_hold_effects;
    @(posedge clk_sys) disable iff (!nrst)
      holdover_status |-> charge_pump_tristate && !loop1_lock &&
                          (loop2_lock == inner_cmp.lock);
  endproperty
  a_hold_effects: assert property (p_hold_effects)
    else $error("holdover outputs wrong");

  property p_fixed_dac;
    @(posedge clk_sys) disable iff (!nrst)
      holdover_status && fixed_dac_enable
        |=> loop1_tune_output == $past(fixed_dac_value);
  endproperty
  a_fixed_dac: assert property (p_fixed_dac)
    else $error("fixed value not driven in holdover");

  property p_auto_exit;
    @(posedge clk_sys) disable iff (!nrst)
      holdover_status && auto_valid && any_eligible
        |=> !holdover_status;
  endproperty
  a_auto_exit: assert property (p_auto_exit)
    else $error("holdover not exited on returning input");

endmodule : rsh_ref_select

// ===== rsh_ref_model.sv
// Reference source model: loss monitors and outer phase detector ticks
`timescale 1ns/1ps
module rsh_ref_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Loss pattern asked for by the bench
  input  wire logic [2:0] lost_req,
  // Monitor flags and detector ticks
  output logic [2:0]      loss_of_signal,
  output logic            loop1_pd_tick
);
  // Loss lags the request by a cycle, as a real monitor would
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loss_of_signal <= 3'h0;
      loop1_pd_tick  <= 1'h0;
    end else begin
      loss_of_signal <= lost_req;
      loop1_pd_tick  <= ~loop1_pd_tick;
    end
  end
endmodule : rsh_ref_model

// ===== tb_top.sv
// Self-checking testbench of the reference selector and holdover control
`timescale 1ns/1ps
module tb_top;
  import rsh_pkg::*;
  logic clk_sys = 0, nrst = 0, auto_select_enable = 0, pin_select_enable = 0;
  logic select_pin_polarity = 0, loss_of_signal_enable = 1;
  logic holdover_exit_choice = 0, holdover_enable = 0, fixed_dac_enable = 0;
  logic dac_tracking_enable = 1, select_pin_zero = 0, select_pin_one = 0;
  logic status_pin_one_in = 0, loop1_compare_strobe = 0, loop1_in_window = 0;
  logic loop2_compare_strobe = 0, loop2_in_window = 0;
  logic [1:0] manual_input_choice = 2'h0;
  logic [2:0] input_buffer_enable = 3'h0, lost_req = 3'h0, loss_of_signal;
  logic [SEL_W-1:0] status_pin_one_select = STAT_LOW;
  logic [SEL_W-1:0] status_pin_two_select = STAT_DAC_ACQ;
  logic [DAC_W-1:0] fixed_dac_value = 10'h000, loop1_tune_voltage = 10'h2ff;
  // Fifty ticks of 200 ns per update keeps the DAC at 100 kHz
  logic [MULT_W-1:0] dac_rate_multiplier = 15'h0005;
  logic [CNTR_W-1:0] dac_rate_counter = 8'h0a;
  logic [LOCK_W-1:0] loop1_lock_count_target = 16'h0003;
  logic [LOCK_W-1:0] loop2_lock_count_target = 16'h0000;
  logic loop1_pd_tick, status_pin_one_out, status_pin_one_oe, status_pin_two;
  logic holdover_status, charge_pump_tristate, loop1_lock, loop2_lock;
  logic dac_acquired_flag;
  logic [1:0] active_input;
  logic [2:0] buffer_run;
  logic [DAC_W-1:0] loop1_tune_output, dac_value_readback;
  logic [15:0] rnd = 16'h003f;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  logic [13:0] q[$];
  event chk_ev;
  string nm [12] = '{"active", "bufrun", "hold", "tristate", "lock1",
    "lock2", "tune", "readback", "acquired", "stat1", "stat2", "oe"};
  rsh_ref_model i_ref (.clk_sys, .nrst, .lost_req, .loss_of_signal,
    .loop1_pd_tick);
  rsh_ref_select i_dut (.clk_sys, .nrst, .auto_select_enable,
    .pin_select_enable, .manual_input_choice, .input_buffer_enable,
    .select_pin_polarity, .loss_of_signal_enable, .holdover_exit_choice,
    .holdover_enable, .fixed_dac_enable, .dac_tracking_enable,
    .fixed_dac_value, .dac_rate_multiplier, .dac_rate_counter,
    .loop1_lock_count_target, .loop2_lock_count_target,
    .status_pin_one_select, .status_pin_two_select, .select_pin_zero,
    .select_pin_one, .status_pin_one_in, .status_pin_one_out,
    .status_pin_one_oe, .status_pin_two, .loss_of_signal, .loop1_pd_tick,
    .loop1_compare_strobe, .loop1_in_window, .loop2_compare_strobe,
    .loop2_in_window, .loop1_tune_voltage, .active_input, .buffer_run,
    .holdover_status, .charge_pump_tristate, .loop1_lock, .loop2_lock,
    .loop1_tune_output, .dac_value_readback, .dac_acquired_flag);
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [9:0] seen(input logic [3:0] id);
    case (id)
      4'h0: seen = {8'h00, active_input};
      4'h1: seen = {7'h00, buffer_run};
      4'h2: seen = {9'h000, holdover_status};
      4'h3: seen = {9'h000, charge_pump_tristate};
      4'h4: seen = {9'h000, loop1_lock};
      4'h5: seen = {9'h000, loop2_lock};
      4'h6: seen = loop1_tune_output;
      4'h7: seen = dac_value_readback;
      4'h8: seen = {9'h000, dac_acquired_flag};
      4'h9: seen = {9'h000, status_pin_one_out};
      4'ha: seen = {9'h000, status_pin_two};
      default: seen = {9'h000, status_pin_one_oe};
    endcase
  endfunction : seen
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [3:0] id, input logic [9:0] got,
                       input logic [9:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm[id], want, got);
    end
  endtask : check
  // Waits until the watcher has taken the note, so nothing moves meanwhile
  task automatic exp(input logic [3:0] id, input logic [9:0] v);
    q.push_back({id, v});
    -> chk_ev;
    wait (q.size() == 0);
  endtask : exp
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  always @(chk_ev) begin : watch
    logic [13:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      check(e[13:10], seen(e[13:10]), e[9:0]);
    end
  end
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 nrst = 1;
    // Fifty ticks per update, one every other cycle: two updates by now
    step(210);
    exp(7, 10'h202);
    exp(8, 10'h000);
    exp(6, 10'h2ff);
    loop1_tune_voltage = 10'h202;
    step(100);
    exp(8, 10'h001);
    exp(10, 10'h001);
    $display("Test tracking finished");
    for (int i = 0; i < 3; i++) begin
      manual_input_choice = i[1:0];
      step(2);
      exp(0, i);
      exp(1, 10'h001 << i);
    end
    status_pin_one_select = STAT_BOTH;
    {loop1_compare_strobe, loop1_in_window} = 2'h3;
    {loop2_compare_strobe, loop2_in_window} = 2'h3;
    step(2);
    exp(4, 10'h000);
    step(1);
    {loop1_compare_strobe, loop2_compare_strobe} = 2'h0;
    exp(4, 10'h001);
    exp(5, 10'h001);
    step(1);
    exp(9, 10'h001);
    {loop1_compare_strobe, loop1_in_window} = 2'h2;
    step(1);
    loop1_compare_strobe = 0;
    exp(4, 10'h000);
    $display("Test lock finished");
    rnd = lfsr(rnd);
    fixed_dac_value = rnd[9:0];
    fixed_dac_enable = 1;
    manual_input_choice = CHOICE_HOLD;
    // Outer loop locks on the very edge holdover is entered
    {loop1_compare_strobe, loop1_in_window} = 2'h3;
    step(2);
    exp(2, 10'h000);
    exp(0, 10'h002);
    holdover_enable = 1;
    status_pin_one_select = STAT_HOLDOVER;
    status_pin_two_select = STAT_INNER;
    step(2);
    exp(2, 10'h001);
    exp(3, 10'h001);
    exp(4, 10'h000);
    exp(5, 10'h001);
    exp(6, rnd[9:0]);
    exp(9, 10'h001);
    exp(10, 10'h001);
    fixed_dac_enable = 0;
    step(2);
    exp(6, 10'h202);
    manual_input_choice = INPUT_ONE;
    status_pin_one_select = STAT_OUTER;
    step(2);
    exp(2, 10'h000);
    exp(0, 10'h001);
    exp(4, 10'h001);
    exp(9, 10'h001);
    $display("Test holdover finished");
    {pin_select_enable, select_pin_polarity, select_pin_zero} = 3'h7;
    step(2);
    exp(0, 10'h002);
    exp(1, 10'h004);
    exp(11, 10'h000);
    select_pin_polarity = 0;
    step(2);
    exp(0, 10'h001);
    {select_pin_one, status_pin_one_in} = 2'h3;
    step(2);
    exp(0, 10'h002);
    status_pin_one_in = 0;
    step(2);
    exp(2, 10'h001);
    exp(0, 10'h002);
    $display("Test pins finished");
    {pin_select_enable, auto_select_enable, input_buffer_enable} = 5'h0e;
    step(3);
    exp(0, 10'h001);
    exp(11, 10'h001);
    lost_req = 3'h2;
    step(4);
    exp(0, 10'h002);
    lost_req = 3'h7;
    step(4);
    exp(2, 10'h001);
    lost_req = 3'h5;
    step(4);
    exp(2, 10'h000);
    exp(0, 10'h001);
    {lost_req, input_buffer_enable} = 6'h07;
    step(4);
    exp(0, 10'h000);
    $display("Test automatic finished");
    end_sim();
  end
endmodule : tb_top
